// [rtl/dpll_profile_feedback_pkg.sv]
// Constants for the profile feedback configuration register bank
package dpll_profile_feedback_pkg;

    // --------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // --------------------------------------------------------------
    localparam logic [29:0] zero_delay_feedback_select_idx = 30'h1602;
    localparam logic [29:0] feedback_mode_control_idx = 30'h1603;
    localparam logic [29:0] loop_bandwidth_byte0_idx = 30'h1604;
    localparam logic [29:0] loop_bandwidth_byte1_idx = 30'h1605;
    localparam logic [29:0] loop_bandwidth_byte2_idx = 30'h1606;
    localparam logic [29:0] loop_bandwidth_byte3_idx = 30'h1607;
    localparam logic [29:0] internal_zero_delay_control_idx = 30'h1616;

    // --------------------------------------------------------------
    // Field positions and widths
    // --------------------------------------------------------------
    localparam int path_width = 5;
    localparam int mode_filter_bit = 7;
    localparam int mode_tag_lsb = 2;
    localparam int tag_width = 3;
    localparam int mode_ext_zd_bit = 1;
    localparam int mode_hitless_bit = 0;
    localparam int int_zd_bit = 0;
    localparam int bw_width = 32;
    localparam int sel_width = 4;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [4:0] path_reset = 5'h00;
    localparam logic [7:0] mode_reset = 8'h00;
    localparam logic [31:0] bw_reset = 32'h0000_0000;

    // --------------------------------------------------------------
    // Tag mode encodings, ascending
    // --------------------------------------------------------------
    localparam logic [2:0] tag_none = 3'h0;
    localparam logic [2:0] tag_reference_only = 3'h1;
    localparam logic [2:0] tag_feedback_only = 3'h2;
    localparam logic [2:0] tag_both_unequal = 3'h3;
    localparam logic [2:0] tag_both_equal = 3'h4;

    // --------------------------------------------------------------
    // AHB transfer type bit for NONSEQ/SEQ
    // --------------------------------------------------------------
    localparam int htrans_active_bit = 1;

endpackage

// [rtl/dpll_profile_feedback_config.sv]
// Register bank for one translation profile's feedback configuration
//
// How it works
// - Path field codes 0..3 pick first reference, companion, second, second companion.
// - Path field codes 0..3 pick first/second output true and complement pins.
// - Internal zero-delay selection acts only while its enable bit is one.
// - Mode bit 7 picks nominal (~70 deg) or high (~88.5 deg) filter set.
// - Mode bits 4:2 give the tag mode, none up to both-equal.
// - Mode bit 1 enables the external zero-delay path in hitless mode.
// - Mode bit 0 is buildout at zero, hitless at one; zero delay needs it.
// - Loop bandwidth is 32 bits over four byte registers, low byte first.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module dpll_profile_feedback_config (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Feedback source selection
    output logic [dpll_profile_feedback_pkg::sel_width-1:0] ext_feedback_reference_select,
    output logic [dpll_profile_feedback_pkg::sel_width-1:0] int_feedback_output_select,
    output logic ext_zero_delay_active,
    output logic int_zero_delay_active,
    // Loop configuration
    output logic high_phase_margin_select,
    output logic [dpll_profile_feedback_pkg::tag_width-1:0] tag_mode,
    output logic hitless_mode,
    output logic [dpll_profile_feedback_pkg::bw_width-1:0] loop_bandwidth
);
    import dpll_profile_feedback_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic wr_pend;
        logic [29:0] wr_idx;
        logic [4:0] path;
        logic [7:0] mode;
        logic [31:0] bw;
        logic int_zd_en;
        logic [31:0] rdata;
        logic [3:0] ext_sel;
        logic [3:0] int_sel;
        logic ext_act;
        logic int_act;
        logic ready;
        logic resp;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Code 0..3 to one-hot; unused codes select nothing
    function automatic logic [3:0] onehot_code(input logic [4:0] code);
        logic [3:0] r;
        r = 4'h0;
        if (code < 5'h04) begin
            r = 4'(4'h1 << code[1:0]);
        end
        return r;
    endfunction

    logic addr_phase;
    assign addr_phase = hsel && hready && htrans[htrans_active_bit];

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.wr_pend = 1'b0;
        // Zero-wait slave that always answers OKAY
        s_d.ready = 1'b1;
        s_d.resp = 1'b0;
        // Data phase of a write lands here, before the read mux sees it
        if (s_q.wr_pend) begin
            unique case (s_q.wr_idx)
                zero_delay_feedback_select_idx: s_d.path = hwdata[path_width-1:0];
                feedback_mode_control_idx: s_d.mode = hwdata[7:0];
                loop_bandwidth_byte0_idx: s_d.bw[7:0] = hwdata[7:0];
                loop_bandwidth_byte1_idx: s_d.bw[15:8] = hwdata[7:0];
                loop_bandwidth_byte2_idx: s_d.bw[23:16] = hwdata[7:0];
                loop_bandwidth_byte3_idx: s_d.bw[31:24] = hwdata[7:0];
                internal_zero_delay_control_idx: s_d.int_zd_en = hwdata[int_zd_bit];
                default: s_d.path = s_d.path;
            endcase
        end
        if (addr_phase) begin
            s_d.wr_pend = hwrite;
            s_d.wr_idx = haddr[31:2];
        end
        // Read data taken from the updated copy so write-then-read is coherent
        if (addr_phase && !hwrite) begin
            unique case (haddr[31:2])
                zero_delay_feedback_select_idx: s_d.rdata = {27'h0, s_d.path};
                feedback_mode_control_idx: s_d.rdata = {24'h0, s_d.mode};
                loop_bandwidth_byte0_idx: s_d.rdata = {24'h0, s_d.bw[7:0]};
                loop_bandwidth_byte1_idx: s_d.rdata = {24'h0, s_d.bw[15:8]};
                loop_bandwidth_byte2_idx: s_d.rdata = {24'h0, s_d.bw[23:16]};
                loop_bandwidth_byte3_idx: s_d.rdata = {24'h0, s_d.bw[31:24]};
                internal_zero_delay_control_idx: s_d.rdata = {31'h0, s_d.int_zd_en};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // Zero delay needs hitless operation as well as its own enable
        s_d.ext_act = s_d.mode[mode_ext_zd_bit] && s_d.mode[mode_hitless_bit];
        s_d.int_act = s_d.int_zd_en && s_d.mode[mode_hitless_bit];
        s_d.ext_sel = s_d.ext_act ? onehot_code(s_d.path) : 4'h0;
        s_d.int_sel = s_d.int_act ? onehot_code(s_d.path) : 4'h0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{wr_pend: 1'b0, wr_idx: 30'h0, path: path_reset, mode: mode_reset,
                     bw: bw_reset, int_zd_en: 1'b0, rdata: 32'h0, ext_sel: 4'h0,
                     int_sel: 4'h0, ext_act: 1'b0, int_act: 1'b0, ready: 1'b1, resp: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign hreadyout = s_q.ready;
    assign hresp = s_q.resp;
    assign hrdata = s_q.rdata;
    assign ext_feedback_reference_select = s_q.ext_sel;
    assign int_feedback_output_select = s_q.int_sel;
    assign ext_zero_delay_active = s_q.ext_act;
    assign int_zero_delay_active = s_q.int_act;
    assign high_phase_margin_select = s_q.mode[mode_filter_bit];
    assign tag_mode = s_q.mode[mode_tag_lsb +: tag_width];
    assign hitless_mode = s_q.mode[mode_hitless_bit];
    assign loop_bandwidth = s_q.bw;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_write_to(logic [29:0] idx);
        addr_phase && hwrite && haddr[31:2] == idx;
    endsequence

    sequence s_read_of(logic [29:0] idx);
        addr_phase && !hwrite && haddr[31:2] == idx;
    endsequence

    // Address phase, then the data phase in which the word lands
    sequence s_write_landed(logic [29:0] idx);
        s_write_to(idx) ##1 1'b1;
    endsequence

    // --------------------------------------------------------------
    // Feedback path selection
    // --------------------------------------------------------------
    a_ext_path_decode: assert property (ext_zero_delay_active && s_q.path < 5'h04 |->
        ext_feedback_reference_select == 4'(4'h1 << s_q.path[1:0]))
        else $error("external feedback select does not match path code");

    a_int_path_decode: assert property (int_zero_delay_active && s_q.path < 5'h04 |->
        int_feedback_output_select == 4'(4'h1 << s_q.path[1:0]))
        else $error("internal feedback select does not match path code");

    a_int_zd_gate: assert property (!(s_q.int_zd_en && hitless_mode) |->
        int_feedback_output_select == 4'h0 && !int_zero_delay_active)
        else $error("internal feedback active without enable");

    a_ext_first_ref: assert property (ext_zero_delay_active && s_q.path == 5'h00 |->
        ext_feedback_reference_select == 4'h1)
        else $error("code 0 misses the first reference");

    a_ext_first_comp: assert property (ext_zero_delay_active && s_q.path == 5'h01 |->
        ext_feedback_reference_select == 4'h2)
        else $error("code 1 misses the first companion");

    a_ext_second_ref: assert property (ext_zero_delay_active && s_q.path == 5'h02 |->
        ext_feedback_reference_select == 4'h4)
        else $error("code 2 misses the second reference");

    a_ext_second_comp: assert property (ext_zero_delay_active && s_q.path == 5'h03 |->
        ext_feedback_reference_select == 4'h8)
        else $error("code 3 misses the second companion");

    a_int_first_true: assert property (int_zero_delay_active && s_q.path == 5'h00 |->
        int_feedback_output_select == 4'h1)
        else $error("code 0 misses the first true pin");

    a_int_first_comp: assert property (int_zero_delay_active && s_q.path == 5'h01 |->
        int_feedback_output_select == 4'h2)
        else $error("code 1 misses the first complement pin");

    a_int_second_true: assert property (int_zero_delay_active && s_q.path == 5'h02 |->
        int_feedback_output_select == 4'h4)
        else $error("code 2 misses the second true pin");

    a_int_second_comp: assert property (int_zero_delay_active && s_q.path == 5'h03 |->
        int_feedback_output_select == 4'h8)
        else $error("code 3 misses the second complement pin");

    a_high_code_idle: assert property (s_q.path >= 5'h04 |->
        ext_feedback_reference_select == 4'h0 && int_feedback_output_select == 4'h0)
        else $error("unused path code selects a source");

    a_ext_sel_gated: assert property (!ext_zero_delay_active |->
        ext_feedback_reference_select == 4'h0)
        else $error("external source selected while inactive");

    a_int_sel_gated: assert property (!int_zero_delay_active |->
        int_feedback_output_select == 4'h0)
        else $error("internal source selected while inactive");

    a_sel_onehot: assert property ($onehot0(ext_feedback_reference_select) &&
        $onehot0(int_feedback_output_select))
        else $error("more than one feedback source selected");

    a_path_write: assert property (s_write_landed(zero_delay_feedback_select_idx) |=>
        s_q.path == $past(hwdata[path_width-1:0]))
        else $error("path field write lost");

    // --------------------------------------------------------------
    // Mode register
    // --------------------------------------------------------------
    a_filter_set_bit: assert property (s_write_landed(feedback_mode_control_idx) |=>
        high_phase_margin_select == $past(hwdata[mode_filter_bit]))
        else $error("filter set does not follow mode bit 7");

    a_tag_mode_field: assert property (s_write_landed(feedback_mode_control_idx) |=>
        tag_mode == $past(hwdata[4:2]))
        else $error("tag mode does not follow mode bits 4:2");

    a_ext_zd_enable: assert property (ext_zero_delay_active ==
        (s_q.mode[mode_ext_zd_bit] && hitless_mode))
        else $error("external zero delay active mismatch");

    a_hitless_needed: assert property (!hitless_mode |->
        !ext_zero_delay_active && !int_zero_delay_active)
        else $error("zero delay active outside hitless mode");

    a_mode_write: assert property (s_write_landed(feedback_mode_control_idx) |=>
        s_q.mode == $past(hwdata[7:0]))
        else $error("mode register write lost");

    a_hitless_bit: assert property (s_write_landed(feedback_mode_control_idx) |=>
        hitless_mode == $past(hwdata[mode_hitless_bit]))
        else $error("hitless mode does not follow bit 0");

    a_ext_zd_write: assert property (s_write_landed(feedback_mode_control_idx) |=>
        ext_zero_delay_active == ($past(hwdata[mode_ext_zd_bit]) && $past(hwdata[mode_hitless_bit])))
        else $error("external zero delay does not follow mode write");

    a_int_zd_write: assert property (s_write_landed(internal_zero_delay_control_idx) |=>
        int_zero_delay_active == ($past(hwdata[int_zd_bit]) && hitless_mode))
        else $error("internal zero delay does not follow its enable");

    a_buildout_idle: assert property (!hitless_mode |->
        ext_feedback_reference_select == 4'h0 && int_feedback_output_select == 4'h0)
        else $error("feedback source selected in buildout mode");

    a_config_holds: assert property (!s_q.wr_pend |=>
        $stable(s_q.mode) && $stable(s_q.path) && $stable(s_q.int_zd_en))
        else $error("configuration changed without a write");

    // --------------------------------------------------------------
    // Loop bandwidth
    // --------------------------------------------------------------
    a_bw_byte_write: assert property (s_write_landed(loop_bandwidth_byte3_idx) |=>
        loop_bandwidth[31:24] == $past(hwdata[7:0]) && $stable(loop_bandwidth[23:0]))
        else $error("loop bandwidth top byte write lost");

    a_bw_read_back: assert property (s_read_of(loop_bandwidth_byte0_idx) |=>
        hrdata == {24'h0, loop_bandwidth[7:0]})
        else $error("loop bandwidth low byte reads wrong");

    a_bw_byte0_write: assert property (s_write_landed(loop_bandwidth_byte0_idx) |=>
        loop_bandwidth[7:0] == $past(hwdata[7:0]) && $stable(loop_bandwidth[31:8]))
        else $error("loop bandwidth byte 0 write lost");

    a_bw_byte1_write: assert property (s_write_landed(loop_bandwidth_byte1_idx) |=>
        loop_bandwidth[15:8] == $past(hwdata[7:0]) && $stable(loop_bandwidth[31:16]) && $stable(loop_bandwidth[7:0]))
        else $error("loop bandwidth byte 1 write lost");

    a_bw_byte2_write: assert property (s_write_landed(loop_bandwidth_byte2_idx) |=>
        loop_bandwidth[23:16] == $past(hwdata[7:0]) && $stable(loop_bandwidth[31:24]) && $stable(loop_bandwidth[15:0]))
        else $error("loop bandwidth byte 2 write lost");

    a_bw_holds: assert property (!s_q.wr_pend |=>
        $stable(loop_bandwidth))
        else $error("loop bandwidth changed without a write");

    a_bw_read_byte1: assert property (s_read_of(loop_bandwidth_byte1_idx) |=>
        hrdata == {24'h0, loop_bandwidth[15:8]})
        else $error("loop bandwidth byte 1 reads wrong");

    a_bw_read_byte2: assert property (s_read_of(loop_bandwidth_byte2_idx) |=>
        hrdata == {24'h0, loop_bandwidth[23:16]})
        else $error("loop bandwidth byte 2 reads wrong");

    a_bw_read_byte3: assert property (s_read_of(loop_bandwidth_byte3_idx) |=>
        hrdata == {24'h0, loop_bandwidth[31:24]})
        else $error("loop bandwidth byte 3 reads wrong");

    // --------------------------------------------------------------
    // Bus and read back
    // --------------------------------------------------------------
    a_resv_read_zero: assert property (s_read_of(zero_delay_feedback_select_idx) |=>
        hrdata[31:5] == 27'h0)
        else $error("reserved path bits read nonzero");

    a_bus_always_ok: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered error");

    a_path_read_back: assert property (s_read_of(zero_delay_feedback_select_idx) |=>
        hrdata == {27'h0, s_q.path})
        else $error("path register reads wrong");

    a_mode_read_back: assert property (s_read_of(feedback_mode_control_idx) |=>
        hrdata == {24'h0, s_q.mode})
        else $error("mode register reads wrong");

    a_filter_read_back: assert property (s_read_of(feedback_mode_control_idx) |=>
        hrdata[mode_filter_bit] == high_phase_margin_select)
        else $error("filter set bit reads wrong");

    a_int_en_read: assert property (s_read_of(internal_zero_delay_control_idx) |=>
        hrdata == {31'h0, s_q.int_zd_en})
        else $error("internal enable register reads wrong");

    a_rdata_holds: assert property (!(addr_phase && !hwrite) |=>
        $stable(hrdata))
        else $error("read data changed outside a read");

endmodule

// [test/dpll_profile_feedback_config_tb.sv]
// Self-checking testbench for the profile feedback configuration bank
`timescale 1ns/1ps
module dpll_profile_feedback_config_tb;
    import dpll_profile_feedback_pkg::*;
    // ------------------------------
    // Signals
    // ------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [3:0] ext_sel;
    logic [3:0] int_sel;
    logic ext_zd, int_zd, hpm, hitless;
    logic [2:0] tag;
    logic [31:0] bw;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    always #4 hclk = ~hclk;
    dpll_profile_feedback_config dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_feedback_reference_select(ext_sel),
        .int_feedback_output_select(int_sel), .ext_zero_delay_active(ext_zd), .int_zero_delay_active(int_zd),
        .high_phase_margin_select(hpm), .tag_mode(tag), .hitless_mode(hitless), .loop_bandwidth(bw));
    // ------------------------------
    // Bus and compare tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; hready is waited on, never assumed
    task automatic addr_phase(input logic [29:0] idx, input logic wr);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {idx, 2'b00};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
    endtask
    task automatic wr(input logic [29:0] idx, input logic [31:0] d);
        addr_phase(idx, 1'b1);
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic rd_chk(input logic [29:0] idx, input logic [31:0] exp);
        addr_phase(idx, 1'b0);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        chk(hrdata, exp);
        chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    endtask
    function automatic logic [31:0] eo(input logic [3:0] e, input logic [3:0] i, input logic [4:0] m);
        return {17'h0, e, i, m[4], m[3], m[2], m[1:0] == 2'h0 ? 3'h0 : 3'h0, m[0]};
    endfunction
    // Output bundle: ext sel, int sel, ext zd, int zd, phase margin, tag, hitless
    task automatic chk_out(input logic [31:0] exp, input logic [2:0] t);
        @(negedge hclk);
        chk({17'h0, ext_sel, int_sel, ext_zd, int_zd, hpm, tag, hitless}, exp | {28'h0, t, 1'b0});
        @(posedge hclk);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic reset_test();
        chk_out(32'h0, 3'h0);
        chk(bw, 32'h0);
        for (int a = 'h1602; a <= 'h1607; a++) rd_chk(30'(a), 32'h0);
        rd_chk(internal_zero_delay_control_idx, 32'h0);
    endtask
    task automatic ext_path_test();
        wr(feedback_mode_control_idx, 32'h0000_0003);
        for (int c = 0; c < 5; c++) begin
            wr(zero_delay_feedback_select_idx, 32'hffff_ffe0 | c);
            rd_chk(zero_delay_feedback_select_idx, 32'(c));
            chk_out(eo(c < 4 ? 4'h1 << c : 4'h0, 4'h0, 5'b10001), 3'h0);
        end
        wr(zero_delay_feedback_select_idx, 32'h0000_0002);
        wr(feedback_mode_control_idx, 32'h0000_0002);
        chk_out(eo(4'h0, 4'h0, 5'b00000), 3'h0);
    endtask
    task automatic int_path_test();
        wr(feedback_mode_control_idx, 32'h0000_0001);
        chk_out(eo(4'h0, 4'h0, 5'b00001), 3'h0);
        wr(internal_zero_delay_control_idx, 32'h0000_0001);
        for (int c = 0; c < 4; c++) begin
            wr(zero_delay_feedback_select_idx, 32'(c));
            chk_out(eo(4'h0, 4'h1 << c, 5'b01001), 3'h0);
        end
        wr(internal_zero_delay_control_idx, 32'h0000_0000);
        chk_out(eo(4'h0, 4'h0, 5'b00001), 3'h0);
    endtask
    task automatic mode_test();
        // Odd tag codes pair with the high margin set so both levels of bit 7 are seen
        for (int t = 0; t < 5; t++) begin
            wr(feedback_mode_control_idx, 32'h60 | (t << 2) | ((t % 2) << 7));
            rd_chk(feedback_mode_control_idx, 32'h60 | (t << 2) | ((t % 2) << 7));
            chk_out(eo(4'h0, 4'h0, {2'b00, 1'(t % 2), 2'b00}), 3'(t));
        end
    endtask
    task automatic bw_test();
        wr(loop_bandwidth_byte0_idx, 32'hdead_be11);
        wr(loop_bandwidth_byte1_idx, 32'h0000_0022);
        wr(loop_bandwidth_byte2_idx, 32'h0000_0033);
        wr(loop_bandwidth_byte3_idx, 32'h0000_0044);
        rd_chk(loop_bandwidth_byte2_idx, 32'h33);
        wr(30'h1608, 32'h0000_00aa);
        rd_chk(30'h1608, 32'h0);
        chk(bw, 32'h4433_2211);
    endtask
    // ------------------------------
    // Sequence and watchdog
    // ------------------------------
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_test();
        ext_path_test();
        int_path_test();
        mode_test();
        bw_test();
        end_of_test();
    end
endmodule
